// File: dsr_defs.svh
// Purpose: Offsets, field positions, reset values and widths of the DMA status block
// Assumes: Included by its bare name from every file that needs it
// Notes:   Definitions only
`ifndef DSR_DEFS_SVH
`define DSR_DEFS_SVH

// Register byte offsets, low address byte only
`define DSR_OFF_COLL      8'h00
`define DSR_OFF_ACTIVITY  8'h04
`define DSR_OFF_IRQ_STAT  8'h08
`define DSR_OFF_IRQ_MASK  8'h0c

// Activity register field positions
`define DSR_LAST_LSB      8
`define DSR_LAST_MSB      11
`define DSR_BUFSEL_MSB    7

// Reset values
`define DSR_LAST_NONE     4'hf
`define DSR_IRQ_MASK_RST  6'h00

// Interrupt status layout
`define DSR_IRQ_W         6
`define DSR_IRQ_XFER_BIT  4
`define DSR_IRQ_BUF_BIT   5

`endif

// File: dsr_pkg.sv
// Purpose: Types shared by the DMA status block
// Assumes: Constants live in dsr_defs.svh
// Notes:   Bus state codes are one-hot
package dsr_pkg;

    typedef logic [7:0] dsr_chan_t;
    typedef logic [3:0] dsr_coll_t;
    typedef logic [3:0] dsr_last_t;

    typedef enum logic [1:0] {
        DSR_IDLE  = 2'b01,
        DSR_WDATA = 2'b10
    } dsr_bus_st_e;

endpackage

// File: dsr_evt_if.sv
// Purpose: Carries controller events and tracked status between bus shell and status core
// Assumes: Single clock domain, all strobes one cycle wide
// Notes:   Top drives events and clears, core returns state
`timescale 1ns/1ps
interface dsr_evt_if;
    dsr_pkg::dsr_chan_t xfer_done;
    dsr_pkg::dsr_chan_t buf_done;
    dsr_pkg::dsr_chan_t pp_mode;
    dsr_pkg::dsr_coll_t coll_evt;
    dsr_pkg::dsr_coll_t coll_clr;
    dsr_pkg::dsr_last_t last_ch;
    dsr_pkg::dsr_chan_t buf_sel;
    dsr_pkg::dsr_coll_t coll_flags;

    modport core (
        input  xfer_done,
        input  buf_done,
        input  pp_mode,
        input  coll_evt,
        input  coll_clr,
        output last_ch,
        output buf_sel,
        output coll_flags
    );

    modport shell (
        output xfer_done,
        output buf_done,
        output pp_mode,
        output coll_evt,
        output coll_clr,
        input  last_ch,
        input  buf_sel,
        input  coll_flags
    );
endinterface

// File: dsr_status_core.sv
// Purpose: Tracks collision flags, last active channel and ping-pong buffer selection
// Assumes: Event strobes are one cycle wide and synchronous to sys_clk
// Notes:   Several completions in one cycle report the highest channel
`timescale 1ns/1ps
`include "dsr_defs.svh"
module dsr_status_core (
    input wire logic  sys_clk,
    input wire logic  rst_n,
    dsr_evt_if.core   ev
);
    import dsr_pkg::*;

    dsr_last_t last_reg;
    dsr_last_t last_next;
    dsr_chan_t bufsel_reg;
    dsr_coll_t coll_reg;

    // Later loop passes win, so the highest completing channel is kept
    always_comb begin
        last_next = last_reg;
        for (int i = 0; i < 8; i++) begin
            if (ev.xfer_done[i]) begin
                last_next = i[3:0]; // RQ3 RQ6
            end
        end
    end

    // Last channel holds all ones until the first completion
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            last_reg <= `DSR_LAST_NONE; // RQ2
        end else begin
            last_reg <= last_next;
        end
    end

    genvar g;
    generate
        // One sticky collision flag per low channel; a new collision beats a clear
        for (g = 0; g < 4; g++) begin : g_coll
            always_ff @(posedge sys_clk or negedge rst_n) begin
                if (!rst_n) begin
                    coll_reg[g] <= 1'b0;
                end else if (ev.coll_evt[g]) begin
                    coll_reg[g] <= 1'b1; // RQ1
                end else if (ev.coll_clr[g]) begin
                    coll_reg[g] <= 1'b0; // RQ1
                end
            end
        end

        // Buffer select flips at each finished buffer; outside ping-pong the primary is used
        for (g = 0; g < 8; g++) begin : g_buf
            always_ff @(posedge sys_clk or negedge rst_n) begin
                if (!rst_n) begin
                    bufsel_reg[g] <= 1'b0;
                end else if (!ev.pp_mode[g]) begin
                    bufsel_reg[g] <= 1'b0; // RQ5
                end else if (ev.buf_done[g]) begin
                    bufsel_reg[g] <= ~bufsel_reg[g]; // RQ5 RQ6
                end
            end
        end
    endgenerate

    assign ev.last_ch    = last_reg;
    assign ev.buf_sel    = bufsel_reg;
    assign ev.coll_flags = coll_reg;

endmodule

// File: dsr_top.sv
// Purpose: AHB-Lite register shell of the DMA status-reporting block
// Assumes: Single word transfers only; hsize is not checked
//          hready is the bus ready, fed back from hreadyout with this single slave
// Notes:   Zero wait states, response always OKAY
//          Register map on the low address byte, one word each:
//          0x00 collision flags of channels 3 to 0, writing 0 clears a flag
//          0x04 activity word, last channel in 11:8, buffer select in 7:0, read-only
//          0x08 interrupt status, cleared by its read; an event in that cycle survives
//          0x0c interrupt mask, same layout as the status
//          Unmapped reads return zero and unmapped writes are dropped
//          Read data is a snapshot taken in the address phase, so an event at that
//          same edge shows up only in the next read
//
// Overview of operation
// RQ1 - Channels 3 to 0 each keep a flag set on a DMA RAM write collision.
// RQ2 - Last-channel field reads all ones after reset until a transfer completes.
// RQ3 - Last-channel field reports the most recent channel 0 to 7, never reserved codes.
// RQ4 - Eight read-only buffer select flags sit at bit equal to channel number.
// RQ5 - A buffer select flag reads 1 on secondary start address, 0 on primary.
// RQ6 - Last channel updates on completion; ping-pong flag toggles when a buffer finishes.
`timescale 1ns/1ps
`include "dsr_defs.svh"
module dsr_top (
    input  wire logic               sys_clk,
    input  wire logic               rst_n,
    input  wire logic               hsel,
    input  wire logic [31:0]        haddr,
    input  wire logic [1:0]         htrans,
    input  wire logic               hwrite,
    input  wire logic [2:0]         hsize,
    input  wire logic [31:0]        hwdata,
    input  wire logic               hready,
    output logic                    hreadyout,
    output logic                    hresp,
    output logic [31:0]             hrdata,
    input  wire dsr_pkg::dsr_chan_t xfer_done,
    input  wire dsr_pkg::dsr_chan_t buf_done,
    input  wire dsr_pkg::dsr_chan_t pp_mode,
    input  wire dsr_pkg::dsr_coll_t coll_evt,
    output logic                    irq
);
    import dsr_pkg::*;

    dsr_evt_if ev ();

    dsr_bus_st_e                  bus_st_reg;
    dsr_bus_st_e                  bus_st_next;
    logic [7:0]                   wr_addr_reg;
    logic [31:0]                  rdata_reg;
    logic [31:0]                  rdata_next;
    logic                         hready_reg;
    logic                         hresp_reg;
    logic                         irq_reg;
    logic [`DSR_IRQ_W-1:0]        irq_stat_reg;
    logic [`DSR_IRQ_W-1:0]        irq_mask_reg;
    logic [`DSR_IRQ_W-1:0]        irq_evt;
    logic [`DSR_IRQ_W-1:0]        irq_rdclr;
    logic                         addr_ok;
    logic                         rd_take;
    logic                         wr_take;
    logic                         wr_do;
    logic [7:0]                   addr_lo;
    logic [31:0]                  activity_word;
    logic [31:0]                  coll_word;

    // Controller events pass straight to the status core
    assign ev.xfer_done = xfer_done;
    assign ev.buf_done  = buf_done;
    assign ev.pp_mode   = pp_mode;
    assign ev.coll_evt  = coll_evt;

    dsr_status_core i_dsr_status_core (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .ev      (ev)
    );

    // Address phase qualification; hsize is ignored as every register is one whole word
    assign addr_lo = haddr[7:0];
    assign addr_ok = hsel && htrans[1] && hready;
    assign rd_take = addr_ok && !hwrite;
    assign wr_take = addr_ok && hwrite;
    assign wr_do   = (bus_st_reg == DSR_WDATA) && hready;

    // Bus phase tracking: a write needs its data phase to see hwdata
    // A write address phase overlapping a data phase keeps the data-phase state
    always_comb begin
        bus_st_next = bus_st_reg;
        case (bus_st_reg)
            DSR_IDLE: begin
                if (wr_take) begin
                    bus_st_next = DSR_WDATA;
                end
            end
            DSR_WDATA: begin
                if (hready) begin
                    bus_st_next = wr_take ? DSR_WDATA : DSR_IDLE;
                end
            end
            default: begin
                bus_st_next = DSR_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_st_reg <= DSR_IDLE;
        end else begin
            bus_st_reg <= bus_st_next;
        end
    end

    // Write address is held for the following data phase
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_addr_reg <= 8'h00;
        end else if (wr_take) begin
            wr_addr_reg <= addr_lo;
        end
    end

    // Writing 0 to a collision bit clears it, writing 1 leaves it alone
    always_comb begin
        ev.coll_clr = 4'h0;
        if (wr_do && (wr_addr_reg == `DSR_OFF_COLL)) begin
            ev.coll_clr = ~hwdata[3:0]; // RQ1
        end
    end

    // Activity word built field by field; bits 31:12 stay zero as unimplemented
    always_comb begin
        activity_word = 32'h00000000;
        activity_word[`DSR_LAST_MSB:`DSR_LAST_LSB] = ev.last_ch; // RQ2 RQ3
        activity_word[`DSR_BUFSEL_MSB:0]           = ev.buf_sel; // RQ4 RQ5
    end

    // Collision word, flags of channels 3 to 0 in the low nibble
    assign coll_word = {28'h0000000, ev.coll_flags}; // RQ1

    // Read data is chosen in the address phase so hrdata leaves a flop in the data phase
    always_comb begin
        rdata_next = rdata_reg;
        if (rd_take) begin
            if (addr_lo == `DSR_OFF_COLL) begin
                rdata_next = coll_word; // RQ1
            end else if (addr_lo == `DSR_OFF_ACTIVITY) begin
                rdata_next = activity_word; // RQ2 RQ3 RQ4
            end else if (addr_lo == `DSR_OFF_IRQ_STAT) begin
                rdata_next = {26'h0, irq_stat_reg};
            end else if (addr_lo == `DSR_OFF_IRQ_MASK) begin
                rdata_next = {26'h0, irq_mask_reg};
            end else begin
                rdata_next = 32'h00000000; // Unmapped reads as zero
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg <= 32'h00000000;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // Never stalls and never errors, so both are constant flops
    // Kept as flops so every bus output leaves a register
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            hready_reg <= 1'b1;
            hresp_reg  <= 1'b0;
        end else begin
            hready_reg <= 1'b1;
            hresp_reg  <= 1'b0;
        end
    end

    // Interrupt sources: collisions, any completion, any buffer switch
    always_comb begin
        irq_evt = {`DSR_IRQ_W{1'b0}};
        irq_evt[3:0] = coll_evt;
        irq_evt[`DSR_IRQ_XFER_BIT] = |xfer_done;
        irq_evt[`DSR_IRQ_BUF_BIT]  = |(buf_done & pp_mode);
    end

    // A status read clears every bit at its address edge
    assign irq_rdclr = (rd_take && (addr_lo == `DSR_OFF_IRQ_STAT)) ? {`DSR_IRQ_W{1'b1}} : {`DSR_IRQ_W{1'b0}};

    // Read clears the sticky bits; an event in the clearing cycle survives
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_stat_reg <= {`DSR_IRQ_W{1'b0}};
        end else begin
            irq_stat_reg <= (irq_stat_reg & ~irq_rdclr) | irq_evt;
        end
    end

    // Mask register, a 1 lets the matching status bit reach irq
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_mask_reg <= `DSR_IRQ_MASK_RST;
        end else if (wr_do && (wr_addr_reg == `DSR_OFF_IRQ_MASK)) begin
            irq_mask_reg <= hwdata[`DSR_IRQ_W-1:0];
        end
    end

    // Registered output costs one cycle of interrupt latency
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    // Outputs straight from their flops
    assign hreadyout = hready_reg;
    assign hresp     = hresp_reg;
    assign hrdata    = rdata_reg;
    assign irq       = irq_reg;

endmodule

// File: dsr_top_monitor.sv
// Purpose: Port-level checks of the DMA status block
// Assumes: Zero wait state bus, one clock domain
// Notes:   Bound to dsr_top at the foot of this file
`timescale 1ns/1ps
module dsr_top_monitor (
    input wire logic               sys_clk,
    input wire logic               rst_n,
    input wire logic               hsel,
    input wire logic [31:0]        haddr,
    input wire logic [1:0]         htrans,
    input wire logic               hwrite,
    input wire logic               hready,
    input wire logic [31:0]        hrdata,
    input wire dsr_pkg::dsr_chan_t xfer_done,
    input wire dsr_pkg::dsr_chan_t pp_mode,
    input wire dsr_pkg::dsr_coll_t coll_evt
);
    import dsr_pkg::*;
    logic seen_reg;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    // Remembers any completion since reset; a completion at the read edge is not in the snapshot
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            seen_reg <= 1'b0;
        else if (xfer_done != 8'h00)
            seen_reg <= 1'b1;
    end
    // Read address phases of the two status words
    sequence s_rd0;
        hsel && htrans[1] && hready && !hwrite && haddr[7:0] == 8'h00;
    endsequence
    sequence s_rd4;
        hsel && htrans[1] && hready && !hwrite && haddr[7:0] == 8'h04;
    endsequence
    property p_coll;
        (coll_evt != 4'h0) ##1 s_rd0 |=> (hrdata[3:0] & $past(coll_evt, 2)) == $past(coll_evt, 2);
    endproperty
    property p_none;
        s_rd4 and !seen_reg |=> hrdata[11:8] == 4'hf;
    endproperty
    property p_range;
        s_rd4 |=> !(hrdata[11:8] inside {[4'h8:4'he]});
    endproperty
    property p_upper;
        s_rd4 |=> hrdata[31:12] == 20'h0;
    endproperty
    property p_off;
        s_rd4 and $stable(pp_mode) |=> (hrdata[7:0] & ~$past(pp_mode)) == 8'h00;
    endproperty
    property p_last;
        $onehot(xfer_done) ##1 (s_rd4 and xfer_done == 8'h00) |=> ($past(xfer_done, 2) >> hrdata[11:8]) == 8'h01;
    endproperty
    a_coll: assert property (p_coll) else $error("collision flag not set");
    a_none: assert property (p_none) else $error("idle channel code wrong");
    a_range: assert property (p_range) else $error("reserved channel code");
    a_upper: assert property (p_upper) else $error("upper bits not zero");
    a_off: assert property (p_off) else $error("buffer select without ping-pong");
    a_last: assert property (p_last) else $error("last channel wrong");
endmodule
bind dsr_top dsr_top_monitor i_dsr_top_monitor (.sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
    .xfer_done(xfer_done), .pp_mode(pp_mode), .coll_evt(coll_evt));

// File: dsr_ctrl_model.sv
// Purpose: Rest of the controller, raising completion, buffer and collision events
// Assumes: Tasks are called just after a rising edge
// Notes:   Strobes last exactly one cycle, as real events do
`timescale 1ns/1ps
module dsr_ctrl_model (
    input  wire logic          sys_clk,
    output dsr_pkg::dsr_chan_t xfer_done,
    output dsr_pkg::dsr_chan_t buf_done,
    output dsr_pkg::dsr_chan_t pp_mode,
    output dsr_pkg::dsr_coll_t coll_evt
);
    import dsr_pkg::*;
    // Quiet at time zero so reset sees no events
    initial begin
        xfer_done = 8'h00;
        buf_done = 8'h00;
        pp_mode = 8'h00;
        coll_evt = 4'h0;
    end
    // One-cycle strobe on one event group
    task pulse(input int kind, input logic [7:0] v);
        case (kind)
            0: xfer_done <= v;
            1: buf_done <= v;
            default: coll_evt <= v[3:0];
        endcase
        @(posedge sys_clk);
        xfer_done <= 8'h00;
        buf_done <= 8'h00;
        coll_evt <= 4'h0;
    endtask
    task set_pp(input logic [7:0] v);
        pp_mode <= v;
        @(posedge sys_clk);
    endtask
endmodule

// File: dsr_status_reporting_test.sv
// Purpose: Self-checking bench of the DMA status block
// Assumes: Zero wait state slave, hready looped back
// Notes:   Tasks are entered just after a rising edge
`timescale 1ns/1ps
module dsr_status_reporting_test;
    import dsr_pkg::*;
    logic               sys_clk = 1'b0;
    logic               rst_n = 1'b0;
    logic               hsel = 1'b0;
    logic               hwrite = 1'b0;
    logic [1:0]         htrans = 2'b00;
    logic [31:0]        haddr = 32'h0;
    logic [31:0]        hwdata = 32'h0;
    logic [31:0]        rd;
    logic               hreadyout;
    logic               hresp;
    logic               irq;
    logic [31:0]        hrdata;
    dsr_chan_t          xfer_done;
    dsr_chan_t          buf_done;
    dsr_chan_t          pp_mode;
    dsr_coll_t          coll_evt;
    int                 failures = 0;
    int                 num_checks = 0;
    int                 cyc = 0;
    dsr_top i_dsr_top (.sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .xfer_done(xfer_done), .buf_done(buf_done),
        .pp_mode(pp_mode), .coll_evt(coll_evt), .irq(irq));
    dsr_ctrl_model i_dsr_ctrl_model (.sys_clk(sys_clk), .xfer_done(xfer_done), .buf_done(buf_done),
        .pp_mode(pp_mode), .coll_evt(coll_evt));
    always #25 sys_clk = ~sys_clk;
    // Hang guard, far above the roughly 125 cycles the tests need
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            failures++;
            tally_and_finish();
        end
    end
    task tally_and_finish();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Single AHB transfer; read data lands in rd at the data phase edge
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task rdchk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(rd, exp);
        check({31'h0, hresp}, 32'h0);
    endtask
    task t_reset();
        rdchk(8'h04, 32'h0f00);
        rdchk(8'h00, 32'h0);
        rdchk(8'h10, 32'h0);
        rdchk(8'h0c, 32'h0);
        check({31'h0, irq}, 32'h0);
        $display("reset values done");
    endtask
    task t_last();
        for (int k = 0; k < 8; k++) begin
            i_dsr_ctrl_model.pulse(0, 8'h01 << k);
            rdchk(8'h04, {20'h0, k[3:0], 8'h00});
        end
        i_dsr_ctrl_model.pulse(0, 8'h24);
        bus(1'b1, 8'h04, 32'h0);
        rdchk(8'h04, 32'h0500);
        $display("last channel done");
    endtask
    task t_pp();
        i_dsr_ctrl_model.set_pp(8'hff);
        for (int k = 0; k < 8; k++) begin
            i_dsr_ctrl_model.pulse(1, 8'h01 << k);
            rdchk(8'h04, 32'h0500 | ((32'h2 << k) - 32'h1));
        end
        i_dsr_ctrl_model.pulse(1, 8'h81);
        rdchk(8'h04, 32'h057e);
        i_dsr_ctrl_model.set_pp(8'h00);
        i_dsr_ctrl_model.pulse(1, 8'h01);
        rdchk(8'h04, 32'h0500);
        $display("buffer select done");
    endtask
    task t_coll();
        for (int k = 0; k < 4; k++) begin
            i_dsr_ctrl_model.pulse(2, 8'h01 << k);
            rdchk(8'h00, (32'h2 << k) - 32'h1);
        end
        bus(1'b1, 8'h00, 32'hb);
        rdchk(8'h00, 32'hb);
        $display("collision done");
    endtask
    // Interrupt raised, read-cleared, then masked
    task t_irq();
        bus(1'b0, 8'h08, 32'h0);
        bus(1'b1, 8'h0c, 32'h10);
        i_dsr_ctrl_model.pulse(0, 8'h02);
        repeat (2) @(posedge sys_clk);
        #1 check({31'h0, irq}, 32'h1);
        @(posedge sys_clk);
        rdchk(8'h08, 32'h10);
        repeat (2) @(posedge sys_clk);
        #1 check({31'h0, irq}, 32'h0);
        @(posedge sys_clk);
        bus(1'b1, 8'h0c, 32'h0);
        i_dsr_ctrl_model.pulse(0, 8'h01);
        repeat (2) @(posedge sys_clk);
        #1 check({31'h0, irq}, 32'h0);
        $display("interrupt done");
    endtask
    // Reset in mid-run after a collision and a mask write brings the activity, collision, mask and irq reset values back
    task t_rerst();
        bus(1'b1, 8'h0c, 32'h3f);
        i_dsr_ctrl_model.pulse(2, 8'h0f);
        rst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        rdchk(8'h04, 32'h0f00);
        rdchk(8'h00, 32'h0);
        rdchk(8'h0c, 32'h0);
        check({31'h0, irq}, 32'h0);
        $display("mid-run reset done");
    endtask
    initial begin
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_reset();
        t_last();
        t_pp();
        t_coll();
        t_irq();
        t_rerst();
        tally_and_finish();
    end
endmodule
